//--- pkg/pmtr_defs.vh
`ifndef PMTR_DEFS_VH
`define PMTR_DEFS_VH
// Reset vector
`define PMTR_RESET_VECTOR 12'h000
// Memory geometry
`define PMTR_WORD_W 16
`define PMTR_ADDR_W_SMALL 11
`define PMTR_ADDR_W_LARGE 12
`define PMTR_PAGE_W 8
// Serial link frame: command, address, data
`define PMTR_CMD_W 4
`define PMTR_SER_ADDR_W 12
`define PMTR_FRAME_W 32
// Link commands
`define PMTR_CMD_RD_PROG 4'h1
`define PMTR_CMD_WR_PROG 4'h2
`define PMTR_CMD_RD_EE 4'h3
`define PMTR_CMD_WR_EE 4'h4
// Table read cycles
`define PMTR_TBL_CYCLES 2
`endif

//--- testbench/pmtr_checker.sv
`timescale 1ns/1ps
`default_nettype none
module pmtr_checker #(
  parameter ADDR_W = 12,
  parameter EMULATION = 0
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  // Table read
  input wire logic tableReadOp,
  input wire logic table_read_lastpage_op,
  input wire logic [7:0] operandAddr,
  input wire logic tableBusy,
  input wire logic tableDone,
  input wire logic [7:0] tableLowAddr,
  input wire logic [7:0] table_high_latch,
  input wire logic [ADDR_W-1:0] progCounter,
  // Pins
  input wire logic prog_serial_dat_oe,
  input wire logic debug_serial_dat_oe,
  input wire logic sharedFuncEnable,
  input wire logic progActive
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence tblReq;
    (tableReadOp || table_read_lastpage_op) && !tableBusy && !progActive && clkEn;
  endsequence
  sequence tblAnswer;
    tableBusy && !tableDone ##1 tableDone && !tableBusy;
  endsequence
  two_cycle_done_a: assert property (tblReq |=> tblAnswer)
    else $error("table read not answered in two cycles");
  done_pulse_a: assert property (tableDone |=> !tableDone)
    else $error("table done longer than one cycle");
  latch_hold_a: assert property (!tableDone |-> $stable(table_high_latch))
    else $error("high latch changed without table read");
  low_addr_a: assert property (tableDone |-> tableLowAddr == $past(operandAddr, 2))
    else $error("low byte destination wrong");
  reset_vector_a: assert property ($rose(rst_n) |-> progCounter == '0)
    else $error("program counter not zero after reset");
  shared_func_a: assert property (sharedFuncEnable == (EMULATION == 0))
    else $error("shared pin function enable wrong");
  debug_quiet_a: assert property (debug_serial_dat_oe |-> EMULATION != 0)
    else $error("debug data driven on real part");
  prog_drive_a: assert property (prog_serial_dat_oe |-> progActive)
    else $error("data pin driven outside link mode");
endmodule // pmtr_checker
bind pmtr_program_memory pmtr_checker #(.ADDR_W(ADDR_W), .EMULATION(EMULATION)) i_pmtr_checker (
  .core_clk(core_clk), .rst_n(rst_n), .clkEn(clkEn), .tableReadOp(tableReadOp),
  .table_read_lastpage_op(table_read_lastpage_op), .operandAddr(operandAddr),
  .tableBusy(tableBusy), .tableDone(tableDone), .tableLowAddr(tableLowAddr),
  .table_high_latch(table_high_latch), .progCounter(progCounter),
  .prog_serial_dat_oe(prog_serial_dat_oe), .debug_serial_dat_oe(debug_serial_dat_oe),
  .sharedFuncEnable(sharedFuncEnable), .progActive(progActive));
`default_nettype wire

//--- testbench/pmtr_programmer.sv
`timescale 1ns/1ps
`default_nettype none
module pmtr_programmer (
  // Device side of data pin
  input wire logic devOut,
  input wire logic devOe,
  // Pin levels
  output var logic serClk,
  output var logic pinLevel
);
  logic drv;
  logic drvOn;
  // Pull-up when released
  always_comb pinLevel = devOe ? devOut : (drvOn ? drv : 1'b1);
  initial begin
    serClk = 1'b0;
    drv = 1'b0;
    drvOn = 1'b0;
  end
  task automatic sendFrame(input logic [31:0] f);
    drvOn = 1'b1;
    for (int i = 31; i >= 0; i--) begin
      drv = f[i];
      #40 serClk = 1'b1;
      #40 serClk = 1'b0;
    end
    drvOn = 1'b0;
    #200;
  endtask
  task automatic readReply(output logic [15:0] w);
    for (int i = 15; i >= 0; i--) begin
      #40 serClk = 1'b1;
      w[i] = pinLevel;
      #40 serClk = 1'b0;
    end
    #200;
  endtask
endmodule // pmtr_programmer
`default_nettype wire

//--- testbench/tb_program_memory_table_read.sv
`timescale 1ns/1ps
`default_nettype none
module tb_program_memory_table_read;
  logic core_clk, rst_n, pcLoad, pcStep, tableReadOp, lastOp, serClk, pinLevel, datOut, datOe;
  logic tableBusy, tableDone, eeWrite, progActive, sharedOn;
  logic clkEn, sharedOut, dbgOut;
  logic [7:0] eeRdData;
  logic [11:0] pcTarget, progCounter;
  logic [7:0] ptrLow, ptrHigh, operandAddr, lowByte, lowAddr, highLatch, eeAddr, eeData;
  logic [15:0] fetchWord, eeSeen, reply;
  int mismatches, comparisons, cycles;
  pmtr_program_memory #(.ADDR_W(12), .EMULATION(0)) i_pmtr_program_memory (
    .core_clk(core_clk), .rst_n(rst_n), .clkEn(clkEn), .pcLoad(pcLoad), .pcTarget(pcTarget),
    .pcStep(pcStep), .progCounter(progCounter), .fetchWord(fetchWord),
    .tableReadOp(tableReadOp), .table_read_lastpage_op(lastOp), .tablePtrLow(ptrLow),
    .tablePtrHigh(ptrHigh), .operandAddr(operandAddr), .tableBusy(tableBusy),
    .tableDone(tableDone), .tableLowByte(lowByte), .tableLowAddr(lowAddr),
    .table_high_latch(highLatch), .prog_serial_clk(serClk), .prog_serial_dat_in(pinLevel),
    .prog_serial_dat_out(datOut), .prog_serial_dat_oe(datOe), .debug_serial_clk(1'b0),
    .debug_serial_dat_in(1'b1), .debug_serial_dat_out(dbgOut), .debug_serial_dat_oe(),
    .sharedFuncOe(1'b0), .sharedFuncOut(sharedOut), .sharedFuncEnable(sharedOn),
    .eeWrite(eeWrite), .eeAddr(eeAddr), .eeWriteData(eeData), .eeReadData(eeRdData),
    .progActive(progActive));
  pmtr_programmer i_pmtr_programmer (.devOut(datOut), .devOe(datOe), .serClk(serClk),
    .pinLevel(pinLevel));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (eeWrite) eeSeen <= {eeAddr, eeData};
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      stop_test();
    end
  end
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic doReset();
    rst_n = 1'b0;
    repeat (3) @(posedge core_clk);
    #1 rst_n = 1'b1;
    @(posedge core_clk) #1;
    check("pc", progCounter, 16'h0000);
    check("shared on", sharedOn, 16'h0001);
    check("shared out", dbgOut, 16'h0001);
  endtask
  task automatic linkSession();
    i_pmtr_programmer.sendFrame({4'h2, 12'h705, 16'h1a2b});
    i_pmtr_programmer.sendFrame({4'h2, 12'hf06, 16'hc3d4});
    i_pmtr_programmer.sendFrame({4'h4, 12'h012, 16'h0099});
    check("ee write", eeSeen, 16'h1299);
    i_pmtr_programmer.sendFrame({4'h1, 12'h705, 16'h0000});
    i_pmtr_programmer.readReply(reply);
    check("reply", reply, 16'h1a2b);
    i_pmtr_programmer.sendFrame({4'h3, 12'h012, 16'h0000});
    i_pmtr_programmer.readReply(reply);
    check("ee reply", reply, 16'h003c);
    check("active", progActive, 16'h0001);
    i_pmtr_programmer.sendFrame({4'h0, 12'h000, 16'h0000});
    check("released", progActive, 16'h0000);
  endtask
  // One table read at a time, never nested
  task automatic tableRead(input logic last, input logic [7:0] hi, lo, op, input logic [15:0] w);
    @(posedge core_clk) #1;
    tableReadOp = !last;
    lastOp = last;
    ptrHigh = hi;
    ptrLow = lo;
    operandAddr = op;
    @(posedge core_clk) #1;
    tableReadOp = 1'b0;
    lastOp = 1'b0;
    ptrLow = ~lo;
    check("busy", tableBusy, 16'h0001);
    @(posedge core_clk) #1;
    check("done", tableDone, 16'h0001);
    check("low byte", lowByte, w[7:0]);
    check("high latch", highLatch, w[15:8]);
    check("low addr", lowAddr, op);
  endtask
  task automatic fetchAt705();
    @(posedge core_clk) #1;
    pcLoad = 1'b1;
    pcTarget = 12'h705;
    @(posedge core_clk) #1;
    pcLoad = 1'b0;
    check("pc load", progCounter, 16'h0705);
    @(posedge core_clk) #1;
    check("fetch", fetchWord, 16'h1a2b);
    clkEn = 1'b0;
    pcStep = 1'b1;
    @(posedge core_clk) #1;
    check("frozen pc", progCounter, 16'h0705);
    clkEn = 1'b1;
    @(posedge core_clk) #1;
    pcStep = 1'b0;
    check("pc step", progCounter, 16'h0706);
  endtask
  initial begin
    {pcLoad, pcStep, tableReadOp, lastOp, pcTarget, ptrLow, ptrHigh, operandAddr} = '0;
    {clkEn, sharedOut, eeRdData} = {1'b1, 1'b1, 8'h3c};
    doReset();
    linkSession();
    doReset();
    tableRead(1'b0, 8'h07, 8'h05, 8'h21, 16'h1a2b);
    tableRead(1'b1, 8'h07, 8'h06, 8'h22, 16'hc3d4);
    tableRead(1'b0, 8'h0f, 8'h06, 8'h23, 16'hc3d4);
    fetchAt705();
    stop_test();
  end
endmodule // tb_program_memory_table_read
`default_nettype wire

//--- verilog/pmtr_program_memory.v
`timescale 1ns/1ps
`default_nettype none
`include "pmtr_defs.vh"
// Contract
// - 16-bit program memory, 2K or 4K words
// - Reset loads program counter with zero
// - Table read reaches any program word
// - Table address is high:low pointer concatenation
// - Low byte goes to operand register
// - High part goes to table high latch
// - Missing high latch bits read zero
// - High latch changes only on table read
// - Table instructions take two cycles
// - Serial data pin bidirectional, programmer clocks
// - Serial link programs flash and EEPROM
// - Debug data bidirectional, debug clock input
// - Emulation disables shared pin functions
// - Debug pins still serve programming
module pmtr_program_memory #(
  parameter ADDR_W = `PMTR_ADDR_W_LARGE,
  parameter EMULATION = 0
) (
  // Clock, reset, enable
  input wire core_clk,
  input wire rst_n,
  input wire clkEn,
  // Core fetch and step
  input wire pcLoad,
  input wire [ADDR_W-1:0] pcTarget,
  input wire pcStep,
  output reg [ADDR_W-1:0] progCounter,
  output reg [15:0] fetchWord,
  // Table read request
  input wire tableReadOp,
  input wire table_read_lastpage_op,
  input wire [7:0] tablePtrLow,
  input wire [7:0] tablePtrHigh,
  input wire [7:0] operandAddr,
  output wire tableBusy,
  output reg tableDone,
  output reg [7:0] tableLowByte,
  output reg [7:0] tableLowAddr,
  output reg [7:0] table_high_latch,
  // Programming serial pins
  input wire prog_serial_clk,
  input wire prog_serial_dat_in,
  output wire prog_serial_dat_out,
  output wire prog_serial_dat_oe,
  // Debug serial pins
  input wire debug_serial_clk,
  input wire debug_serial_dat_in,
  output wire debug_serial_dat_out,
  output wire debug_serial_dat_oe,
  // Shared pin functions and EEPROM port
  input wire sharedFuncOe,
  input wire sharedFuncOut,
  output wire sharedFuncEnable,
  output reg eeWrite,
  output reg [7:0] eeAddr,
  output reg [7:0] eeWriteData,
  input wire [7:0] eeReadData,
  output wire progActive
);
  localparam DEPTH = 1 << ADDR_W;
  localparam ST_IDLE = 2'b01;
  localparam ST_SECOND = 2'b10;
  // ----------------------------------------
  // Storage
  // ----------------------------------------
  reg [`PMTR_WORD_W-1:0] flashMem [0:DEPTH-1];
  reg [1:0] tblState;
  reg [ADDR_W-1:0] tblAddr;
  reg [7:0] tblDest;
  reg [1:0] linkMode;
  wire frameValid;
  wire [3:0] frameCmd;
  wire [11:0] frameAddr;
  wire [15:0] frameData;
  wire linkDatOut;
  wire linkDatOe;
  reg readLoad;
  reg [15:0] readWord;
  // Pins merged: debug pins double as programming pins
  wire linkClk = EMULATION ? debug_serial_clk : prog_serial_clk;
  wire linkDat = EMULATION ? debug_serial_dat_in : prog_serial_dat_in;
  // Table address, full pointer or last page
  function [ADDR_W-1:0] tableAddress;
    input lastPage;
    input [7:0] lo;
    input [7:0] hi;
    reg [15:0] full;
    begin
      full = {hi, lo};
      if (lastPage)
        tableAddress = {{(ADDR_W-8){1'b1}}, lo};
      else
        tableAddress = full[ADDR_W-1:0];
    end
  endfunction
  assign tableBusy = (tblState == ST_SECOND);
  assign sharedFuncEnable = (EMULATION == 0);
  assign progActive = (linkMode != 2'h0);
  assign prog_serial_dat_out = EMULATION ? 1'b0 : linkDatOut;
  assign prog_serial_dat_oe = EMULATION ? 1'b0 : linkDatOe;
  // Shared function sets debug data out only on real part, whether linked or not; debug_serial_dat_oe stays 0 there
  assign debug_serial_dat_out = EMULATION ? linkDatOut : sharedFuncOut;
  assign debug_serial_dat_oe = EMULATION ? linkDatOe : 1'b0;
  pmtr_serial_link uLink (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .serClkPin(linkClk),
    .serDatIn(linkDat),
    .serDatOut(linkDatOut),
    .serDatOe(linkDatOe),
    .frameValid(frameValid),
    .frameCmd(frameCmd),
    .frameAddr(frameAddr),
    .frameData(frameData),
    .readWord(readWord),
    .readLoad(readLoad)
  );
  // ----------------------------------------
  // Program counter and fetch
  // ----------------------------------------
  always @(posedge core_clk) begin
    if (!rst_n) begin
      progCounter <= {ADDR_W{1'b0}};
      fetchWord <= 16'h0000;
    end else if (clkEn && !progActive) begin
      if (pcLoad)
        progCounter <= pcTarget;
      else if (pcStep && !tableBusy)
        progCounter <= progCounter + {{(ADDR_W-1){1'b0}}, 1'b1};
      fetchWord <= flashMem[progCounter];
    end
  end
  // ----------------------------------------
  // Table read sequencer
  // ----------------------------------------
  always @(posedge core_clk) begin
    if (!rst_n) begin
      tblState <= ST_IDLE;
      tblAddr <= {ADDR_W{1'b0}};
      tblDest <= 8'h00;
      tableDone <= 1'b0;
      tableLowByte <= 8'h00;
      tableLowAddr <= 8'h00;
      table_high_latch <= 8'h00;
    end else if (clkEn) begin
      tableDone <= 1'b0;
      case (tblState)
        ST_IDLE: begin
          if ((tableReadOp || table_read_lastpage_op) && !progActive) begin
            tblAddr <= tableAddress(table_read_lastpage_op, tablePtrLow, tablePtrHigh);
            tblDest <= operandAddr;
            tblState <= ST_SECOND;
          end
        end
        ST_SECOND: begin
          tableLowByte <= flashMem[tblAddr][7:0];
          tableLowAddr <= tblDest;
          table_high_latch <= flashMem[tblAddr][15:8];
          tableDone <= 1'b1;
          tblState <= ST_IDLE;
        end
        default: tblState <= ST_IDLE;
      endcase
    end
  end
  // ----------------------------------------
  // Serial programming of flash and EEPROM
  // ----------------------------------------
  always @(posedge core_clk) begin
    if (!rst_n) begin
      linkMode <= 2'h0;
      readLoad <= 1'b0;
      readWord <= 16'h0000;
      eeWrite <= 1'b0;
      eeAddr <= 8'h00;
      eeWriteData <= 8'h00;
    end else if (clkEn) begin
      readLoad <= 1'b0;
      eeWrite <= 1'b0;
      if (frameValid) begin
        linkMode <= 2'h1;
        case (frameCmd)
          `PMTR_CMD_WR_PROG: flashMem[frameAddr[ADDR_W-1:0]] <= frameData;
          `PMTR_CMD_RD_PROG: begin
            readWord <= flashMem[frameAddr[ADDR_W-1:0]];
            readLoad <= 1'b1;
          end
          `PMTR_CMD_WR_EE: begin
            eeWrite <= 1'b1;
            eeAddr <= frameAddr[7:0];
            eeWriteData <= frameData[7:0];
          end
          `PMTR_CMD_RD_EE: begin
            readWord <= {8'h00, eeReadData};
            readLoad <= 1'b1;
          end
          default: linkMode <= 2'h0;
        endcase
      end
    end
  end
endmodule // pmtr_program_memory
`default_nettype wire

//--- verilog/pmtr_serial_link.v
`timescale 1ns/1ps
`default_nettype none
`include "pmtr_defs.vh"
module pmtr_serial_link (
  // Clock and reset
  input wire core_clk,
  input wire rst_n,
  input wire clkEn,
  // Raw pins
  input wire serClkPin,
  input wire serDatIn,
  output reg serDatOut,
  output reg serDatOe,
  // Decoded frame
  output reg frameValid,
  output reg [`PMTR_CMD_W-1:0] frameCmd,
  output reg [`PMTR_SER_ADDR_W-1:0] frameAddr,
  output reg [15:0] frameData,
  // Read-back word
  input wire [15:0] readWord,
  input wire readLoad
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  reg [1:0] clkSync;
  reg [1:0] datSync;
  reg clkPrev;
  reg [5:0] bitCount;
  reg [`PMTR_FRAME_W-1:0] shiftIn;
  reg [15:0] shiftOut;
  reg txArmed;
  wire riseEdge = clkSync[1] & ~clkPrev;
  wire fallEdge = ~clkSync[1] & clkPrev;
  always @(posedge core_clk) begin
    if (!rst_n) begin
      clkSync <= 2'h0;
      datSync <= 2'h0;
      clkPrev <= 1'b0;
      bitCount <= 6'h00;
      shiftIn <= 32'h00000000;
      shiftOut <= 16'h0000;
      txArmed <= 1'b0;
      serDatOut <= 1'b0;
      serDatOe <= 1'b0;
      frameValid <= 1'b0;
      frameCmd <= 4'h0;
      frameAddr <= 12'h000;
      frameData <= 16'h0000;
    end else if (clkEn) begin
      clkSync <= {clkSync[0], serClkPin};
      datSync <= {datSync[0], serDatIn};
      clkPrev <= clkSync[1];
      frameValid <= 1'b0;
      // ----------------------------------------
      // Sample on rising edge of programmer clock
      // ----------------------------------------
      if (riseEdge && !serDatOe) begin
        shiftIn <= {shiftIn[`PMTR_FRAME_W-2:0], datSync[1]};
        if (bitCount == 6'h1f) begin
          bitCount <= 6'h00;
          frameValid <= 1'b1;
          frameCmd <= shiftIn[30:27];
          frameAddr <= shiftIn[26:15];
          frameData <= {shiftIn[14:0], datSync[1]};
        end else begin
          bitCount <= bitCount + 6'h01;
        end
      end
      // Upload read word, changed on falling edge
      // Only a fall after a rise shifts: the frame's own trailing fall must not
      if (readLoad) begin
        shiftOut <= readWord;
        bitCount <= 6'h00;
        serDatOe <= 1'b1;
        serDatOut <= readWord[15];
        txArmed <= 1'b0;
      end else if (serDatOe && riseEdge) begin
        txArmed <= 1'b1;
      end else if (serDatOe && fallEdge && txArmed) begin
        txArmed <= 1'b0;
        shiftOut <= {shiftOut[14:0], 1'b0};
        serDatOut <= shiftOut[14];
        if (bitCount == 6'h0f) begin
          bitCount <= 6'h00;
          serDatOe <= 1'b0;
        end else begin
          bitCount <= bitCount + 6'h01;
        end
      end
    end
  end
endmodule // pmtr_serial_link
`default_nettype wire
